// [design/instr_field_split.sv]
`timescale 1ns/10ps
`include "instruction_word_decoder_regs.svh"

module instr_field_split
  import instruction_word_decoder_pkg::*;
(
  input  wire logic [`IWD_WORD_W-1:0]   word_in,
  output instruction_word_decoder_pkg::decoded_s fields_out
);

  wire logic [1:0] cls      = word_in[`IWD_CLASS_HI:`IWD_CLASS_LO];
  wire logic [3:0] byte_op  = word_in[`IWD_BYTEOP_HI:`IWD_BYTEOP_LO];
  wire logic [1:0] bit_op   = word_in[`IWD_BITOP_HI:`IWD_BITOP_LO];
  wire logic [1:0] lit_top  = word_in[`IWD_LITOP_HI:`IWD_LITOP_HI-1];
  wire logic       is_byte  = (cls == `IWD_CLS_BYTE);
  wire logic       is_bit   = (cls == `IWD_CLS_BIT);
  wire logic       is_jump  = (cls == `IWD_CLS_JUMP);
  wire logic       is_lit   = (cls == `IWD_CLS_LIT);
  wire logic [6:0] reg_loc  = word_in[`IWD_REG_HI:`IWD_REG_LO];
  wire logic       to_reg   = word_in[`IWD_DEST_BIT];
  wire logic       writes_f = (is_byte && to_reg && byte_op != 4'h0)
                           || (is_byte && byte_op == 4'h0 && to_reg)
                           || (is_bit && !bit_op[1]);
  // idle word ignores its don't-care bits
  wire logic       idle     = ((word_in & `IWD_IDLE_MASK) == `IWD_IDLE_VALUE);
  wire logic       ret_word = (word_in == `IWD_WORD_SUB_RET)
                           || (word_in == `IWD_WORD_INT_RET);
  wire logic       ret_lit  = is_lit && (lit_top == `IWD_LOP_RET_LIT);

  assign fields_out.class_sel      = is_byte ? CLASS_BYTE :
                                     is_bit  ? CLASS_BIT  : CLASS_LIT;
  assign fields_out.reg_loc        = (is_byte || is_bit) ? reg_loc : 7'h00;
  assign fields_out.to_register    = is_byte && to_reg;
  assign fields_out.bit_pos        = is_bit ? word_in[`IWD_BITPOS_HI:`IWD_BITPOS_LO] : 3'h0;
  // eleven-bit target for jumps, eight-bit constant for literal ops, zero otherwise
  assign fields_out.literal        = is_jump ? word_in[`IWD_LIT11_HI:0] :
                                     is_lit  ? {3'h0, word_in[`IWD_LIT8_HI:0]} : 11'h000;
  assign fields_out.literal_long   = is_jump;
  assign fields_out.is_idle_cycle  = idle;
  assign fields_out.bit_rmw        = is_bit && !bit_op[1];
  assign fields_out.bit_value      = is_bit && (bit_op == `IWD_OP_BIT_SET);
  assign fields_out.bit_test       = is_bit && bit_op[1];
  assign fields_out.flags_override = writes_f && (reg_loc == `IWD_REG_FLAGS);
  assign fields_out.pcl_write      = writes_f && (reg_loc == `IWD_REG_PC_LOW);
  assign fields_out.pc_change      = is_jump || ret_word || ret_lit;

endmodule : instr_field_split

// [design/instruction_word_decoder.sv]
// How it works
// - take 14-bit words, split into opcode and operand fields
// - sort each word into byte, bit or literal/control class
// - byte ops take operand register from the location field
// - destination bit clear sends result to accumulator, set to register
// - register location is seven bits, 0x00 to 0x7F
// - bit ops select one of eight bits in the named register
// - literal ops carry an eight or eleven bit constant
// - don't-care bits are ignored whatever their value
// - ordinary instructions finish in one instruction cycle
// - true bit test or pc change takes two cycles, second idles
// - one instruction cycle is four oscillator periods
// - flag results override written zero, carry and digit_carry_flag bits
// - bit set and clear are read-modify-write of whole byte
// - program_counter_low write loads high byte from pc_high_holding_latch
`timescale 1ns/10ps
`include "instruction_word_decoder_regs.svh"

module instruction_word_decoder
  import instruction_word_decoder_pkg::*;
(
  input  wire logic                          ref_clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic [`IWD_WORD_W-1:0]        word_in,
  input  wire logic                          word_valid_in,
  input  wire logic                          test_true_in,
  output instruction_word_decoder_pkg::decoded_s decoded_out,
  output logic                               decoded_valid_out,
  output logic                               cycle_start_out,
  output logic                               cycle_end_out,
  output logic                               flush_out,
  output logic                               second_cycle_out,
  output logic [1:0]                         phase_out
);

  decoded_s fields;
  phase_e   phase_q;
  phase_e   phase_d;
  decoded_s dec_q;
  logic     valid_q;
  logic     flush_q;
  logic     second_q;
  logic     start_q;
  logic     end_q;
  logic [1:0] phase_idx_q;

  instr_field_split u_split (
    .word_in    (word_in),
    .fields_out (fields)
  );

  // four oscillator periods per instruction cycle
  always_comb begin
    case (phase_q)
      PH_Q1:   phase_d = PH_Q2;
      PH_Q2:   phase_d = PH_Q3;
      PH_Q3:   phase_d = PH_Q4;
      PH_Q4:   phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
  end

  wire logic at_q1      = (phase_q == PH_Q1);
  wire logic at_q4      = (phase_q == PH_Q4);
  wire logic load_word  = at_q1 && word_valid_in;
  // skip taken when the datapath reports the test true at the Q4 edge of the cycle
  wire logic skip_taken = dec_q.bit_test && test_true_in;
  wire logic two_cycle  = valid_q && !second_q
                       && (dec_q.pc_change || dec_q.pcl_write || skip_taken);
  wire logic [1:0] phase_idx_d = (phase_q == PH_Q1) ? 2'h0 :
                                 (phase_q == PH_Q2) ? 2'h1 :
                                 (phase_q == PH_Q3) ? 2'h2 : 2'h3;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q     <= PH_Q1;
      phase_idx_q <= 2'h0;
      start_q     <= 1'b0;
      end_q       <= 1'b0;
    end else begin
      phase_q     <= phase_d;
      phase_idx_q <= phase_idx_d;
      start_q     <= at_q1;
      end_q       <= at_q4;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dec_q   <= '0;
      valid_q <= 1'b0;
    end else if (load_word) begin
      dec_q   <= fields;
      valid_q <= 1'b1;
    end else if (at_q1) begin
      valid_q <= 1'b0;
    end
  end

  // flush the prefetched word so the second cycle idles
  // second mark follows the flushed word into its own cycle
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flush_q  <= 1'b0;
      second_q <= 1'b0;
    end else if (at_q4) begin
      flush_q  <= two_cycle;
    end else if (at_q1) begin
      second_q <= flush_q;
    end
  end

  // during the flushed cycle decoded_valid_out is low while decoded_out keeps the flushed word's fields
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      decoded_out       <= '0;
      decoded_valid_out <= 1'b0;
    end else begin
      decoded_out       <= dec_q;
      decoded_valid_out <= valid_q && !second_q;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flush_out        <= 1'b0;
      second_cycle_out <= 1'b0;
      cycle_start_out  <= 1'b0;
      cycle_end_out    <= 1'b0;
      phase_out        <= 2'h0;
    end else begin
      flush_out        <= flush_q;
      second_cycle_out <= second_q;
      cycle_start_out  <= start_q;
      cycle_end_out    <= end_q;
      phase_out        <= phase_idx_q;
    end
  end

endmodule : instruction_word_decoder

// [design/instruction_word_decoder_pkg.sv]
package instruction_word_decoder_pkg;

  typedef enum logic [1:0] {
    CLASS_BYTE = 2'h0,
    CLASS_BIT  = 2'h1,
    CLASS_LIT  = 2'h2
  } instr_class_e;

  typedef struct packed {
    instr_class_e class_sel;
    logic [6:0]   reg_loc;
    logic         to_register;
    logic [2:0]   bit_pos;
    logic [10:0]  literal;
    logic         literal_long;
    logic         is_idle_cycle;
    logic         bit_rmw;
    logic         bit_value;
    logic         bit_test;
    logic         flags_override;
    logic         pcl_write;
    logic         pc_change;
  } decoded_s;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_e;

endpackage : instruction_word_decoder_pkg

// [design/instruction_word_decoder_regs.svh]
`ifndef INSTRUCTION_WORD_DECODER_REGS_SVH
`define INSTRUCTION_WORD_DECODER_REGS_SVH

// word layout
`define IWD_WORD_W        14
`define IWD_CLASS_HI      13
`define IWD_CLASS_LO      12
`define IWD_REG_HI        6
`define IWD_REG_LO        0
`define IWD_DEST_BIT      7
`define IWD_BITPOS_HI     9
`define IWD_BITPOS_LO     7
`define IWD_BITOP_HI      11
`define IWD_BITOP_LO      10
`define IWD_LIT8_HI       7
`define IWD_LIT11_HI      10
`define IWD_GOTO_BIT      11
`define IWD_BYTEOP_HI     11
`define IWD_BYTEOP_LO     8
`define IWD_LITOP_HI      11
`define IWD_LITOP_LO      8

// class codes in bits 13:12
`define IWD_CLS_BYTE      2'h0
`define IWD_CLS_BIT       2'h1
`define IWD_CLS_JUMP      2'h2
`define IWD_CLS_LIT       2'h3

// sub-opcodes
`define IWD_OP_DEC_SKIP   4'hB
`define IWD_OP_INC_SKIP   4'hF
`define IWD_OP_TEST_CLR   2'h2
`define IWD_OP_TEST_SET   2'h3
`define IWD_OP_BIT_CLR    2'h0
`define IWD_OP_BIT_SET    2'h1
`define IWD_LOP_RET_LIT   2'h1
`define IWD_WORD_SUB_RET  14'h0008
`define IWD_WORD_INT_RET  14'h0009
`define IWD_IDLE_MASK     14'h3F9F
`define IWD_IDLE_VALUE    14'h0000

// special registers
`define IWD_REG_PC_LOW    7'h02
`define IWD_REG_FLAGS     7'h03
`define IWD_REG_LAST      7'h7F

// timing
`define IWD_OSC_PER_CYCLE 4
`define IWD_PHASE_W       2

`endif

// [tb/instruction_word_decoder_monitor.sv]
`timescale 1ns/10ps
module instruction_word_decoder_monitor
  import instruction_word_decoder_pkg::*;
(
  input wire logic                                   ref_clk_in,
  input wire logic                                   rst_n_in,
  input wire instruction_word_decoder_pkg::decoded_s decoded_out,
  input wire logic                                   decoded_valid_out,
  input wire logic                                   cycle_start_out,
  input wire logic                                   cycle_end_out,
  input wire logic                                   flush_out,
  input wire logic                                   second_cycle_out,
  input wire logic [1:0]                             phase_out
);
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_phase_step: assert property ($past(rst_n_in, 3) |-> phase_out == $past(phase_out) + 2'h1)
    else $error("phase index skipped");
  a_start_period: assert property (cycle_start_out |=> !cycle_start_out [*3] ##1 cycle_start_out)
    else $error("cycle start not once per four clocks");
  a_fields_stand: assert property ($changed(decoded_out) |=> $stable(decoded_out) [*3])
    else $error("decoded fields changed within a cycle");
  a_flush_blank: assert property ($rose(flush_out) |=> !decoded_valid_out [*4])
    else $error("flushed cycle shows a live word");
  a_end_then_start: assert property (cycle_end_out |=> cycle_start_out)
    else $error("cycle end not followed by cycle start");
  a_flush_pair: assert property ($rose(flush_out) |=> $rose(second_cycle_out))
    else $error("second cycle mark missing");
  a_lit_short: assert property (decoded_out.class_sel == CLASS_LIT && !decoded_out.literal_long
    |-> decoded_out.literal[10:8] == 3'h0)
    else $error("short literal not zero extended");
  a_class_known: assert property (decoded_valid_out |-> decoded_out.class_sel != 2'h3)
    else $error("undefined class");
  a_rmw_bitclass: assert property (decoded_valid_out && decoded_out.bit_rmw
    |-> decoded_out.class_sel == CLASS_BIT && !decoded_out.bit_test)
    else $error("bit update outside bit class");
  a_pcl_target: assert property (decoded_valid_out && decoded_out.pcl_write
    |-> decoded_out.reg_loc == 7'h02 && (decoded_out.to_register || decoded_out.bit_rmw))
    else $error("pc low write to wrong place");
endmodule : instruction_word_decoder_monitor

bind instruction_word_decoder instruction_word_decoder_monitor mon_u (.ref_clk_in, .rst_n_in,
  .decoded_out, .decoded_valid_out, .cycle_start_out, .cycle_end_out, .flush_out,
  .second_cycle_out, .phase_out);

// [tb/instruction_word_decoder_tb_top.sv]
`timescale 1ns/10ps
module instruction_word_decoder_tb_top;
  import instruction_word_decoder_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        test_true_in = 1'b0;
  logic [13:0] next_word = 14'h0000;
  logic [13:0] word, cur;
  logic [13:0] cand;
  logic        wr;
  logic        word_valid, dvalid, flush;
  logic        blank = 1'b0;
  logic [31:0] seed = 32'h04BD406D;
  int          fail_count = 0;
  int          checked = 0;
  decoded_s    dec;
  localparam logic [13:0] DIR_W [20] = '{14'h2805, 14'h0000, 14'h2005, 14'h0000, 14'h0008,
    14'h0000, 14'h0009, 14'h0000, 14'h3405, 14'h0000, 14'h0082, 14'h0000, 14'h1402, 14'h0000,
    14'h1803, 14'h1C03, 14'h0002, 14'h0060, 14'h1183, 14'h0883};
  always #5 ref_clk_in = ~ref_clk_in;
  word_fetch_model fetch_u (.clk_in(ref_clk_in), .rst_n_in, .next_word_in(next_word),
    .word_out(word), .valid_out(word_valid));
  instruction_word_decoder dut_u (.ref_clk_in, .rst_n_in, .word_in(word),
    .word_valid_in(word_valid), .test_true_in, .decoded_out(dec), .decoded_valid_out(dvalid),
    .cycle_start_out(), .cycle_end_out(), .flush_out(flush), .second_cycle_out(),
    .phase_out());
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic two_cyc(input logic [13:0] w, input logic t);
    return w[13:12] == 2'h2 || w == 14'h0008 || w == 14'h0009 || w[13:10] == 4'hD
      || (w[13:12] == 2'h0 && w[7:0] == 8'h82) || (w[13:11] == 3'h3 && t)
      || (w[13:11] == 3'h2 && w[6:0] == 7'h02);
  endfunction : two_cyc
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 80; i++) begin
      @(posedge ref_clk_in);
      cur = word;
      wr = (cur[13:12] == 2'h0 && cur[7]) || cur[13:11] == 3'h2;
      seed = lfsr(seed);
      cand = seed[13:0] & ((seed[13:3] == 11'h00C) ? 14'h3FFC : 14'h3FFF);
      #1;
      test_true_in = seed[20];
      next_word = i < 20 ? DIR_W[i] : cand;
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk("valid", dvalid, !blank);
      chk("flush", flush, blank);
      if (!blank) begin
        chk("class", dec.class_sel, cur[13] ? 2'h2 : cur[13:12]);
        chk("idle", dec.is_idle_cycle, (cur & 14'h3F9F) == 14'h0000);
        if (!cur[13]) chk("reg", dec.reg_loc, cur[6:0]);
        if (cur[13:12] == 2'h0) chk("dest", dec.to_register, cur[7]);
        if (cur[13:12] == 2'h1) chk("bitpos", dec.bit_pos, cur[9:7]);
        if (cur[13:12] == 2'h1) chk("rmw", dec.bit_rmw, !cur[11]);
        if (cur[13:12] == 2'h1) chk("btest", dec.bit_test, cur[11]);
        if (cur[13]) chk("lit", dec.literal, cur[12] ? {3'h0, cur[7:0]} : cur[10:0]);
        chk("long", dec.literal_long, cur[13:12] == 2'h2);
        chk("setval", dec.bit_value, cur[13:10] == 4'h5);
        chk("pcwr", dec.pcl_write, wr && cur[6:0] == 7'h02);
        chk("flagwr", dec.flags_override, wr && cur[6:0] == 7'h03);
        chk("pcchg", dec.pc_change, cur[13:12] == 2'h2 || cur[13:10] == 4'hD || cur[13:1] == 13'h0004);
      end
      blank = !blank && two_cyc(cur, test_true_in);
      if (i == 21 || i == 79) $display("test through word %0d done", i);
    end
    close_out();
  end
endmodule : instruction_word_decoder_tb_top

// [tb/word_fetch_model.sv]
`timescale 1ns/10ps
module word_fetch_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [13:0] next_word_in,
  output logic [13:0]      word_out,
  output logic             valid_out
);
  logic [1:0] slot_q;
  initial word_out = 14'h0000;
  initial valid_out = 1'b1;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_q <= 2'h0;
    end else begin
      slot_q <= slot_q + 2'h1;
    end
  end
  // whole word changes just after the take edge, then holds four clocks
  always @(posedge clk_in) begin
    if (rst_n_in && slot_q == 2'h0) begin
      word_out <= #1 next_word_in;
    end
  end
endmodule : word_fetch_model
